// *** hdl/flash_id_pkg.sv ***
// constants shared by the identification-read host controller
package flash_id_pkg;
   // ------------------------------------------------------------
   // address layout
   // ------------------------------------------------------------
   localparam int ADDR_W        = 23;
   localparam int SECT_W        = 7;
   localparam int SECT_LSB      = 16;
   localparam int HV_PIN_BIT    = 9;
   localparam int SEL_BIT_A6    = 6;
   localparam logic [6:0] LAST_SECTOR = 7'h7F;
   // ------------------------------------------------------------
   // code selectors on A3..A0
   // ------------------------------------------------------------
   localparam logic [3:0] SEL_MAKER   = 4'h0;
   localparam logic [3:0] SEL_DEV1    = 4'h1;
   localparam logic [3:0] SEL_DEV2    = 4'hE;
   localparam logic [3:0] SEL_DEV3    = 4'hF;
   localparam logic [3:0] SEL_PROTECT = 4'h2;
   localparam logic [3:0] SEL_SECURE  = 4'h3;
   // ------------------------------------------------------------
   // request kinds
   // ------------------------------------------------------------
   localparam logic [2:0] OP_MAKER    = 3'h0;
   localparam logic [2:0] OP_DEV1     = 3'h1;
   localparam logic [2:0] OP_DEV2     = 3'h2;
   localparam logic [2:0] OP_DEV3     = 3'h3;
   localparam logic [2:0] OP_PROTECT  = 3'h4;
   localparam logic [2:0] OP_SECURE   = 3'h5;
   localparam logic [2:0] OP_ARRAY    = 3'h6;
   // ------------------------------------------------------------
   // answer decoding
   // ------------------------------------------------------------
   localparam int LOCK_FLAG_BIT    = 7;
   localparam int PROT_FLAG_BIT    = 0;
   localparam logic [7:0] SEC_HIGH_LOCKED = 8'h98;
   localparam logic [7:0] SEC_HIGH_OPEN   = 8'h18;
   localparam logic [7:0] SEC_LOW_LOCKED  = 8'h88;
   localparam logic [7:0] SEC_LOW_OPEN    = 8'h08;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int SETUP_NS      = 200;
   localparam int ACCESS_NS     = 110;
   localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// *** hdl/wait_counter.sv ***
// down-counter that flags when a programmed wait has run out
module wait_counter #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   // control
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] count,
   // status
   output logic                  done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [WIDTH-1:0] cnt_q;

   initial begin
      if (WIDTH < 1) $error("wait_counter needs WIDTH >= 1");
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= count;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   // done looks at the count alone, so a caller may build load from it without a loop
   assign done = (cnt_q == '0);
endmodule

// *** hdl/flash_id_host.sv ***
// host controller that reads identification and protection codes from the flash pins
// Function
// - high-voltage entry: raised A9, chip select and output drive low, write high
// - A6 held low, A3..A0 pick the code, middle bits driven zero
// - protect check: sector on top bits, A1 high, A0 low; bit0 means protected
// - in-system mode: codes reached by command, raised voltage not used; the host writes no command and keeps write high
// - all control and address levels settle before data is sampled
module flash_id_host
   import flash_id_pkg::*;
#(
   parameter int SETUP_CYCLES  = SETUP_CYC,
   parameter int ACCESS_CYCLES = ACCESS_CYC
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // request side
   input  wire logic              reqValid,
   input  wire logic [2:0]        reqOp,
   input  wire logic [SECT_W-1:0] reqSector,
   input  wire logic [15:0]       reqArrayLow,
   input  wire logic              reqInSystem,
   output logic                   reqReady,
   // answer side
   output logic                   ansValid,
   output logic [7:0]             ansCode,
   output logic [7:0]             ansHigh,
   output logic                   ansProtected,
   output logic                   ansFactoryLocked,
   output logic                   ansLowVariant,
   output logic                   ansLastSector,
   // flash pins
   output logic [ADDR_W-1:0]      flashAddr,
   output logic                   idHighVoltage,
   output logic                   chipSelN,
   output logic                   outDriveN,
   output logic                   writeStrobeN,
   input  wire logic [7:0]        dataLowByte,
   input  wire logic [7:0]        dataHighByte
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      if (SETUP_CYCLES < 1 || SETUP_CYCLES > 255) $error("bad SETUP_CYCLES");
      if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 255) $error("bad ACCESS_CYCLES");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_SETUP  = 4'b0010,
      ST_ACCESS = 4'b0100,
      ST_DONE   = 4'b1000
   } state_t;

   state_t state_q;
   logic [2:0] op_q;
   logic [7:0] lowSync1_q, lowSync2_q, highSync1_q, highSync2_q;
   logic       waitLoad;
   logic [7:0] waitCount;
   logic       waitDone;

   // pins pass two flops before use
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lowSync1_q  <= 8'h00;
         lowSync2_q  <= 8'h00;
         highSync1_q <= 8'h00;
         highSync2_q <= 8'h00;
      end else begin
         lowSync1_q  <= dataLowByte;
         lowSync2_q  <= lowSync1_q;
         highSync1_q <= dataHighByte;
         highSync2_q <= highSync1_q;
      end
   end

   wait_counter #(.WIDTH(8)) u_wait (
      .mclk  (mclk),
      .rst   (rst),
      .load  (waitLoad),
      .count (waitCount),
      .done  (waitDone)
   );

   // setup covers pin settling; access adds two sync stages
   // answer pulse lands SETUP_CYCLES + ACCESS_CYCLES + 4 edges after the request is taken
   always_comb begin
      waitLoad  = 1'b0;
      waitCount = 8'h00;
      if (state_q == ST_IDLE && reqValid) begin
         waitLoad  = 1'b1;
         waitCount = 8'(SETUP_CYCLES);
      end else if (state_q == ST_SETUP && waitDone) begin
         waitLoad  = 1'b1;
         waitCount = 8'(ACCESS_CYCLES + 2);
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         op_q    <= OP_ARRAY;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (reqValid) begin
                  state_q <= ST_SETUP;
                  op_q    <= reqOp;
               end
            end
            ST_SETUP:  if (waitDone) state_q <= ST_ACCESS;
            ST_ACCESS: if (waitDone) state_q <= ST_DONE;
            ST_DONE:   state_q <= ST_IDLE;
            default:   state_q <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // pin drive: address and high voltage set in setup, read strobes after
   // ------------------------------------------------------------
   function automatic logic [3:0] sel_of(input logic [2:0] op);
      case (op)
         OP_MAKER:   sel_of = SEL_MAKER;
         OP_DEV1:    sel_of = SEL_DEV1;
         OP_DEV2:    sel_of = SEL_DEV2;
         OP_DEV3:    sel_of = SEL_DEV3;
         OP_PROTECT: sel_of = SEL_PROTECT;
         OP_SECURE:  sel_of = SEL_SECURE;
         default:    sel_of = SEL_MAKER;
      endcase
   endfunction

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flashAddr     <= '0;
         idHighVoltage <= 1'b0;
      end else if (state_q == ST_IDLE && reqValid) begin
         if (reqOp == OP_ARRAY) begin
            // plain read: sector on top bits, offset below
            flashAddr     <= {reqSector, reqArrayLow};
            idHighVoltage <= 1'b0;
         end else begin
            flashAddr <= '0;
            flashAddr[3:0] <= sel_of(reqOp);
            flashAddr[SEL_BIT_A6] <= 1'b0;
            if (reqOp == OP_PROTECT)
               flashAddr[ADDR_W-1:SECT_LSB] <= reqSector;
            // in-system mode leaves A9 at logic level
            idHighVoltage <= !reqInSystem;
         end
      end else if (state_q == ST_DONE) begin
         idHighVoltage <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         chipSelN     <= 1'b1;
         outDriveN    <= 1'b1;
         writeStrobeN <= 1'b1;
      end else begin
         writeStrobeN <= 1'b1;
         chipSelN     <= !(state_q == ST_SETUP && waitDone) && !(state_q == ST_ACCESS
                         && !waitDone);
         outDriveN    <= !(state_q == ST_SETUP && waitDone) && !(state_q == ST_ACCESS
                         && !waitDone);
      end
   end

   // ------------------------------------------------------------
   // answer capture
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ansValid         <= 1'b0;
         ansCode          <= 8'h00;
         ansHigh          <= 8'h00;
         ansProtected     <= 1'b0;
         ansFactoryLocked <= 1'b0;
         ansLowVariant    <= 1'b0;
         ansLastSector    <= 1'b0;
      end else begin
         ansValid <= 1'b0;
         if (state_q == ST_ACCESS && waitDone) begin
            ansValid <= 1'b1;
            ansCode  <= lowSync2_q;
            ansHigh  <= highSync2_q;
            ansProtected <= (op_q == OP_PROTECT) && lowSync2_q[PROT_FLAG_BIT];
            ansFactoryLocked <= (op_q == OP_SECURE) && lowSync2_q[LOCK_FLAG_BIT];
            // 88h/08h mean the low-sector variant, 98h/18h the high one
            ansLowVariant <= (op_q == OP_SECURE) && (lowSync2_q == SEC_LOW_LOCKED
                             || lowSync2_q == SEC_LOW_OPEN);
            ansLastSector <= (flashAddr[ADDR_W-1:SECT_LSB] == LAST_SECTOR);
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reqReady <= 1'b0;
      end else begin
         reqReady <= (state_q == ST_DONE) || (state_q == ST_IDLE && !reqValid);
      end
   end
endmodule

// *** sim/flash_id_host_props.sv ***
// assertions on the identification-read host controller ports
module flash_id_host_props
   import flash_id_pkg::*;
#(
   parameter int SETUP_CYCLES  = SETUP_CYC,
   parameter int ACCESS_CYCLES = ACCESS_CYC
) (
   // clock and reset
   input wire logic              mclk,
   input wire logic              rst,
   // request and answer
   input wire logic              reqValid,
   input wire logic [2:0]        reqOp,
   input wire logic              reqInSystem,
   input wire logic              reqReady,
   input wire logic              ansValid,
   input wire logic [7:0]        ansCode,
   input wire logic              ansProtected,
   input wire logic              ansFactoryLocked,
   input wire logic              ansLastSector,
   // flash pins
   input wire logic [ADDR_W-1:0] flashAddr,
   input wire logic              idHighVoltage,
   input wire logic              chipSelN,
   input wire logic              outDriveN,
   input wire logic              writeStrobeN
);
   timeunit 1ns;
   timeprecision 1ns;
   // answer pulse is first seen high one edge after it is launched
   localparam int LAT   = SETUP_CYCLES + ACCESS_CYCLES + 5;
   localparam int LOWM1 = ACCESS_CYCLES + 2;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // request steps
   // ------------------------------------------------------------
   sequence s_take;
      reqValid && reqReady;
   endsequence
   sequence s_answer;
      ##LAT ansValid;
   endsequence
   sequence s_strobe;
      !outDriveN ##LOWM1 !chipSelN ##1 chipSelN;
   endsequence
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_answer_time: assert property (s_take |-> s_answer)
      else $error("answer not at fixed latency");
   a_write_high: assert property (writeStrobeN)
      else $error("write strobe driven low");
   a_hv_before: assert property ($rose(idHighVoltage) |-> chipSelN && outDriveN)
      else $error("raised voltage not ahead of strobes");
   a_strobe_len: assert property ($fell(chipSelN) |-> s_strobe)
      else $error("strobe window has wrong length");
   a_addr_steady: assert property (!chipSelN |-> $stable(flashAddr) && $stable(idHighVoltage))
      else $error("pins moved while reading");
   a_id_middle: assert property (idHighVoltage |-> flashAddr[15:4] == 12'h000)
      else $error("middle address bits not zero");
   a_no_raise: assert property (s_take ##0 (reqInSystem || reqOp == OP_ARRAY) |=> !idHighVoltage[*4])
      else $error("voltage raised without need");
   a_prot_flag: assert property (ansValid && idHighVoltage && flashAddr[3:0] == SEL_PROTECT
      |-> ansProtected == ansCode[PROT_FLAG_BIT])
      else $error("protect flag mismatch");
   a_lock_flag: assert property (ansValid && idHighVoltage && flashAddr[3:0] == SEL_SECURE
      |-> ansFactoryLocked == ansCode[LOCK_FLAG_BIT])
      else $error("lock flag mismatch");
   a_last_sector: assert property (ansValid |-> ansLastSector == (flashAddr[22:16] == LAST_SECTOR))
      else $error("last sector flag mismatch");
   a_hv_drop: assert property (ansValid && idHighVoltage |=> !idHighVoltage)
      else $error("raised voltage kept after answer");
endmodule

// *** sim/flash_model.sv ***
// behavioural flash answering identification and array reads
module flash_model
   import flash_id_pkg::*;
#(
   parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
   parameter logic [7:0] DEV_UPPER  = 8'h3C, // arbitrary value
   parameter logic [7:0] DEV_CYC1   = 8'h41, // arbitrary value
   parameter logic [7:0] DEV_CYC2   = 8'h42, // arbitrary value
   parameter logic [7:0] DEV_CYC3   = 8'h43  // arbitrary value
) (
   // pins from the host
   input wire logic [ADDR_W-1:0] flashAddr,
   input wire logic              idHighVoltage,
   input wire logic              chipSelN,
   input wire logic              outDriveN,
   input wire logic              writeStrobeN,
   // bench controls
   input wire logic              cmdMode,
   input wire logic              lowVariant,
   input wire logic              factoryLocked,
   // data pins
   output logic [7:0]            dataLowByte,
   output logic [7:0]            dataHighByte
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        sel;
   logic        idMode;
   logic [15:0] word;
   logic [15:0] lastWord = 16'h5555;
   assign sel = !chipSelN && !outDriveN && writeStrobeN;
   // a raised A6 falls back to array data, so a host slip is visible
   assign idMode = sel && (idHighVoltage || cmdMode) && !flashAddr[SEL_BIT_A6];
   always_comb begin
      word = flashAddr[15:0] ^ {9'h000, flashAddr[22:16]};
      if (idMode) begin
         case (flashAddr[3:0])
            SEL_MAKER:   word = {8'h00, MAKER_CODE};
            SEL_DEV1:    word = {DEV_UPPER, DEV_CYC1};
            SEL_DEV2:    word = {DEV_UPPER, DEV_CYC2};
            SEL_DEV3:    word = {DEV_UPPER, DEV_CYC3};
            SEL_PROTECT: word = {15'h0000, flashAddr[22:16] == LAST_SECTOR};
            SEL_SECURE:  word = {8'h00, factoryLocked, 2'h0, !lowVariant, 4'h8};
            default:     word = 16'hA5C3;
         endcase
      end
   end
   always @(word, sel) begin
      if (sel)
         lastWord = word;
   end
   // released bus shows the inverse so stale data never passes
   assign {dataHighByte, dataLowByte} = sel ? word : ~lastWord;
endmodule

// *** sim/flash_id_host_tb_top.sv ***
// self-checking bench for the identification-read host controller
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module flash_id_host_tb_top
   import flash_id_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] MK = 8'h5A; // arbitrary value
   localparam logic [7:0] DU = 8'h3C; // arbitrary value
   logic mclk, rst, reqValid, reqInSystem, reqReady, ansValid;
   logic ansProtected, ansFactoryLocked, ansLowVariant, ansLastSector;
   logic idHighVoltage, chipSelN, outDriveN, writeStrobeN;
   logic cmdMode, lowVariant, factoryLocked;
   logic [2:0] reqOp;
   logic [6:0] reqSector;
   logic [15:0] reqArrayLow;
   logic [7:0] ansCode, ansHigh, dataLowByte, dataHighByte;
   logic [ADDR_W-1:0] flashAddr;
   int fails, cmpCount;
   flash_id_host DUT (.mclk, .rst, .reqValid, .reqOp, .reqSector, .reqArrayLow,
      .reqInSystem, .reqReady, .ansValid, .ansCode, .ansHigh, .ansProtected,
      .ansFactoryLocked, .ansLowVariant, .ansLastSector, .flashAddr, .idHighVoltage,
      .chipSelN, .outDriveN, .writeStrobeN, .dataLowByte, .dataHighByte);
   flash_model #(.MAKER_CODE(MK), .DEV_UPPER(DU)) u_flash (.flashAddr, .idHighVoltage,
      .chipSelN, .outDriveN, .writeStrobeN, .cmdMode, .lowVariant, .factoryLocked,
      .dataLowByte, .dataHighByte);
   always #50 mclk = ~mclk;
   task automatic stop_test();
      $display("compares=%0d mismatches=%0d", cmpCount, fails);
      if (fails == 0 && cmpCount > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // one request, returns 1 ns after the edge that raises the answer pulse, while it is still high
   task automatic run(input logic [2:0] op, input logic [6:0] sec, input logic [15:0] low,
                      input logic ins);
      int n;
      repeat (2) @(posedge mclk);
      reqOp       <= op;
      reqSector   <= sec;
      reqArrayLow <= low;
      reqInSystem <= ins;
      reqValid    <= 1'h1;
      @(posedge mclk);
      reqValid    <= 1'h0;
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (ansValid !== 1'h1 && n < 20);
      if (n >= 20) begin
         fails++;
         stop_test();
      end
   endtask
   task automatic s_ident();
      logic [15:0] exp [4] = '{{8'h00, MK}, {DU, 8'h41}, {DU, 8'h42}, {DU, 8'h43}};
      logic [3:0]  sel [4] = '{SEL_MAKER, SEL_DEV1, SEL_DEV2, SEL_DEV3};
      for (int i = 0; i < 4; i++) begin
         run(3'(i), 7'h00, 16'h0000, 1'h0);
         `CHK({ansHigh, ansCode}, exp[i])
         `CHK(flashAddr, {19'h00000, sel[i]})
         `CHK(idHighVoltage, 1'h1)
      end
   endtask
   task automatic s_protect();
      for (int i = 0; i < 2; i++) begin
         run(OP_PROTECT, i ? LAST_SECTOR : 7'h05, 16'h0000, 1'h0);
         `CHK(ansCode, {7'h00, i[0]})
         `CHK(ansProtected, i[0])
         `CHK(flashAddr[22:16], i ? LAST_SECTOR : 7'h05)
      end
   endtask
   task automatic s_secure();
      logic [7:0] exp [4] = '{SEC_HIGH_OPEN, SEC_HIGH_LOCKED, SEC_LOW_OPEN, SEC_LOW_LOCKED};
      for (int i = 0; i < 4; i++) begin
         lowVariant = i[1];
         factoryLocked = i[0];
         run(OP_SECURE, 7'h00, 16'h0000, 1'h0);
         `CHK(ansCode, exp[i])
         `CHK(ansFactoryLocked, i[0])
         `CHK(ansLowVariant, i[1])
      end
   endtask
   task automatic s_modes();
      cmdMode = 1'h1;
      run(OP_MAKER, 7'h00, 16'h0000, 1'h1);
      `CHK(ansCode, MK)
      `CHK(idHighVoltage, 1'h0)
      cmdMode = 1'h0;
      // top word of the last sector; low nibble looks like a code selector
      run(OP_ARRAY, LAST_SECTOR, 16'hFFFF, 1'h0);
      `CHK({ansHigh, ansCode}, 16'hFF80)
      `CHK(flashAddr, 23'h7FFFFF)
      `CHK(ansLastSector, 1'h1)
   endtask
   initial begin
      {mclk, reqValid, reqInSystem, reqOp, reqSector, reqArrayLow} = '0;
      {cmdMode, lowVariant, factoryLocked, fails, cmpCount} = '0;
      rst = 1'h1;
      repeat (6) @(posedge mclk);
      rst <= 1'h0;
      s_ident();
      s_protect();
      s_secure();
      s_modes();
      stop_test();
   end
endmodule
bind flash_id_host flash_id_host_props #(.SETUP_CYCLES(SETUP_CYCLES),
   .ACCESS_CYCLES(ACCESS_CYCLES)) u_props (.mclk, .rst, .reqValid, .reqOp, .reqInSystem,
   .reqReady, .ansValid, .ansCode, .ansProtected, .ansFactoryLocked, .ansLastSector,
   .flashAddr, .idHighVoltage, .chipSelN, .outDriveN, .writeStrobeN);
